// ---- logic/rcb_bank.sv ----
// Purpose: Configuration and status register bank of a sub-GHz transceiver.
// Assumes: Strength and CRC status come from logic on CORE_CLK_I.
// Notes: Unmapped addresses read zero and ignore writes.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "rcb_map.svh"
module rcb_bank
  import rcb_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic [7:0] STRENGTH_I,
  input wire logic CRC_OK_I,
  input wire logic TUNE_CYCLE_I,
  output logic [2:0] CHIP_STATE_O,
  output logic [1:0] BAND_SELECT_O,
  output logic [1:0] VCO_TUNE_OFFSET_O,
  output logic DIVIDER_SET_SELECT_O,
  output logic [1:0] MODULATION_SELECT_O,
  output logic [1:0] DATA_MODE_O,
  output logic [1:0] OOK_THRESHOLD_TYPE_O,
  output logic [1:0] INTERMEDIATE_GAIN_SELECT_O,
  output logic [31:0] SYNC_WORD_O,
  output logic [7:0] OOK_CONFIG_O,
  output logic [7:0] TRANSMIT_CONFIG_O,
  output logic [7:0] CLOCK_OUTPUT_O,
  output logic [7:0] PAYLOAD_CONFIG_O,
  output logic [7:0] NODE_ADDRESS_O,
  output logic [7:0] PACKET_CONFIG_O,
  output logic [7:0] FIFO_CRC_CONFIG_O
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] general_reg;
  logic [7:0] general_next;
  logic [7:0] datamod_reg;
  logic [7:0] ook_reg;
  logic [7:0] sync_reg [0:3];
  logic [7:0] tx_reg;
  logic [7:0] clkout_reg;
  logic [7:0] payload_reg;
  logic [7:0] node_reg;
  logic [7:0] packet_reg;
  logic [7:0] fifocrc_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_general = WR_I && hit(ADDR_I, `RCB_ADDR_GENERAL);
  wire wr_datamod = WR_I && hit(ADDR_I, `RCB_ADDR_DATAMOD);
  wire wr_ook = WR_I && hit(ADDR_I, `RCB_ADDR_OOK);
  wire wr_tx = WR_I && hit(ADDR_I, `RCB_ADDR_TX);
  wire wr_clkout = WR_I && hit(ADDR_I, `RCB_ADDR_CLKOUT);
  wire wr_payload = WR_I && hit(ADDR_I, `RCB_ADDR_PAYLOAD);
  wire wr_node = WR_I && hit(ADDR_I, `RCB_ADDR_NODE);
  wire wr_packet = WR_I && hit(ADDR_I, `RCB_ADDR_PACKET);
  wire wr_fifocrc = WR_I && hit(ADDR_I, `RCB_ADDR_FIFOCRC);
  wire sync_sel = (ADDR_I >= `RCB_ADDR_SYNC1) && (ADDR_I <= `RCB_ADDR_SYNC4);
  wire [1:0] sync_idx = 2'(ADDR_I - `RCB_ADDR_SYNC1);
  // The CRC status bit is owned by the packet engine, not software.
  wire [7:0] packet_view = {packet_reg[7:1], CRC_OK_I};

  // Tuning offset flips on each control cycle; a write in the same cycle wins.
  wire [1:0] vco_now = general_reg[`RCB_VCO_HI:`RCB_VCO_LO];
  wire [1:0] vco_toggled = TUNE_CYCLE_I ? ~vco_now : vco_now;
  assign general_next = wr_general ? WDATA_I :
    {general_reg[7:3], vco_toggled, general_reg[`RCB_DIV_BIT]};

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        `RCB_ADDR_GENERAL: rdata_next = general_reg;
        `RCB_ADDR_DATAMOD: rdata_next = datamod_reg;
        `RCB_ADDR_STRENGTH: rdata_next = STRENGTH_I;
        `RCB_ADDR_OOK: rdata_next = ook_reg;
        `RCB_ADDR_SYNC1, `RCB_ADDR_SYNC2, `RCB_ADDR_SYNC3, `RCB_ADDR_SYNC4: rdata_next = sync_reg[sync_idx];
        `RCB_ADDR_TX: rdata_next = tx_reg;
        `RCB_ADDR_CLKOUT: rdata_next = clkout_reg;
        `RCB_ADDR_PAYLOAD: rdata_next = payload_reg;
        `RCB_ADDR_NODE: rdata_next = node_reg;
        `RCB_ADDR_PACKET: rdata_next = packet_view;
        `RCB_ADDR_FIFOCRC: rdata_next = fifocrc_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      general_reg <= `RCB_RST_GENERAL;
      datamod_reg <= `RCB_RST_DATAMOD;
      rdata_reg <= 8'h00;
    end else begin
      general_reg <= general_next;
      rdata_reg <= rdata_next;
      if (wr_datamod) begin
        datamod_reg <= WDATA_I;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      ook_reg <= `RCB_RST_OTHER;
      tx_reg <= `RCB_RST_OTHER;
      clkout_reg <= `RCB_RST_OTHER;
      payload_reg <= `RCB_RST_OTHER;
      node_reg <= `RCB_RST_OTHER;
      packet_reg <= `RCB_RST_OTHER;
      fifocrc_reg <= `RCB_RST_OTHER;
    end else begin
      if (wr_ook) ook_reg <= WDATA_I;
      if (wr_tx) tx_reg <= WDATA_I;
      if (wr_clkout) clkout_reg <= WDATA_I;
      if (wr_payload) payload_reg <= WDATA_I;
      if (wr_node) node_reg <= WDATA_I;
      if (wr_packet) packet_reg <= WDATA_I;
      if (wr_fifocrc) fifocrc_reg <= WDATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < 4; i++) sync_reg[i] <= `RCB_RST_OTHER;
    end else if (WR_I && sync_sel) begin
      sync_reg[sync_idx] <= WDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA_O = rdata_reg;
  // Reserved codes 101..111 are not expected from software and pass unchanged.
  assign CHIP_STATE_O = general_reg[`RCB_CHIP_HI:`RCB_CHIP_LO];
  assign BAND_SELECT_O = general_reg[`RCB_BAND_HI:`RCB_BAND_LO];
  assign VCO_TUNE_OFFSET_O = vco_now;
  assign DIVIDER_SET_SELECT_O = general_reg[`RCB_DIV_BIT];
  assign MODULATION_SELECT_O = datamod_reg[`RCB_MOD_HI:`RCB_MOD_LO];
  // Packet mode ignores the low bit.
  assign DATA_MODE_O = datamod_reg[`RCB_DMHI_BIT] ? 2'(RCB_PACKET) :
    {1'b0, datamod_reg[`RCB_DMLO_BIT]};
  assign OOK_THRESHOLD_TYPE_O = datamod_reg[`RCB_OOKT_HI:`RCB_OOKT_LO];
  assign INTERMEDIATE_GAIN_SELECT_O = datamod_reg[`RCB_GAIN_HI:`RCB_GAIN_LO];
  assign SYNC_WORD_O = {sync_reg[0], sync_reg[1], sync_reg[2], sync_reg[3]};
  assign OOK_CONFIG_O = ook_reg;
  assign TRANSMIT_CONFIG_O = tx_reg;
  assign CLOCK_OUTPUT_O = clkout_reg;
  assign PAYLOAD_CONFIG_O = payload_reg;
  assign NODE_ADDRESS_O = node_reg;
  assign PACKET_CONFIG_O = packet_view;
  assign FIFO_CRC_CONFIG_O = fifocrc_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_gen_write;
    WR_I && ADDR_I == `RCB_ADDR_GENERAL;
  endsequence

  a_reset_general: assert property ($rose(RESET_N_I) |-> general_reg == `RCB_RST_GENERAL) else $error("general reset");
  a_reset_datamod: assert property ($rose(RESET_N_I) |-> datamod_reg == `RCB_RST_DATAMOD) else $error("data reset");
  a_vco_toggle: assert property (!WR_I && TUNE_CYCLE_I |=> VCO_TUNE_OFFSET_O == ~$past(VCO_TUNE_OFFSET_O)) else $error("tune toggle");
  a_gen_readback: assert property (s_gen_write ##1 (RD_I && ADDR_I == `RCB_ADDR_GENERAL && !TUNE_CYCLE_I && !WR_I) |=> RDATA_O == $past(WDATA_I, 2)) else $error("general readback");
  a_chip_field: assert property (s_gen_write |=> CHIP_STATE_O == $past(WDATA_I[7:5])) else $error("chip field");
  a_data_mode: assert property (datamod_reg[2] |-> DATA_MODE_O == 2'h2) else $error("packet mode");
  a_strength_read: assert property (RD_I && ADDR_I == `RCB_ADDR_STRENGTH |=> RDATA_O == $past(STRENGTH_I)) else $error("strength read");
  a_sync_order: assert property (WR_I && ADDR_I == `RCB_ADDR_SYNC1 |=> SYNC_WORD_O[31:24] == $past(WDATA_I)) else $error("sync order");
  a_read_idle: assert property (!RD_I |=> RDATA_O == 8'h00) else $error("idle read");
  a_crc_status: assert property (RD_I && ADDR_I == `RCB_ADDR_PACKET |=> RDATA_O[0] == $past(CRC_OK_I)) else $error("crc status");

endmodule

// ---- logic/rcb_map.svh ----
// Purpose: Register offsets, field positions and reset values of the radio configuration bank.
// Assumes: Byte-wide registers at their printed byte offsets.
// Notes: Definitions only.
`ifndef RCB_MAP_SVH
`define RCB_MAP_SVH
`define RCB_ADDR_GENERAL 8'h00
`define RCB_ADDR_DATAMOD 8'h01
`define RCB_ADDR_STRENGTH 8'h14
`define RCB_ADDR_OOK 8'h15
`define RCB_ADDR_SYNC1 8'h16
`define RCB_ADDR_SYNC2 8'h17
`define RCB_ADDR_SYNC3 8'h18
`define RCB_ADDR_SYNC4 8'h19
`define RCB_ADDR_TX 8'h1A
`define RCB_ADDR_CLKOUT 8'h1B
`define RCB_ADDR_PAYLOAD 8'h1C
`define RCB_ADDR_NODE 8'h1D
`define RCB_ADDR_PACKET 8'h1E
`define RCB_ADDR_FIFOCRC 8'h1F
`define RCB_RST_GENERAL 8'h28
`define RCB_RST_DATAMOD 8'h88
`define RCB_RST_OTHER 8'h00
`define RCB_CHIP_HI 7
`define RCB_CHIP_LO 5
`define RCB_BAND_HI 4
`define RCB_BAND_LO 3
`define RCB_VCO_HI 2
`define RCB_VCO_LO 1
`define RCB_DIV_BIT 0
`define RCB_MOD_HI 7
`define RCB_MOD_LO 6
`define RCB_DMLO_BIT 5
`define RCB_OOKT_HI 4
`define RCB_OOKT_LO 3
`define RCB_DMHI_BIT 2
`define RCB_GAIN_HI 1
`define RCB_GAIN_LO 0
`define RCB_CRC_STAT_BIT 0
`endif

// ---- logic/rcb_pkg.sv ----
// Purpose: Types of the radio configuration bank.
// Assumes: Codes as held in the general and data registers.
// Notes: Types only.
package rcb_pkg;
  typedef enum logic [2:0] {
    RCB_SLEEP = 3'h0,
    RCB_STANDBY = 3'h1,
    RCB_SYNTH = 3'h2,
    RCB_RECEIVE = 3'h3,
    RCB_TRANSMIT = 3'h4
  } rcb_chip_state_type;
  typedef enum logic [1:0] {
    RCB_CONTINUOUS = 2'h0,
    RCB_BUFFERED = 2'h1,
    RCB_PACKET = 2'h2
  } rcb_data_mode_type;
  typedef enum logic [1:0] {
    RCB_MOD_NONE = 2'h0,
    RCB_MOD_OOK = 2'h1,
    RCB_MOD_FSK = 2'h2
  } rcb_modulation_type;
endpackage

// ---- verification/rcb_bank_test.sv ----
// Purpose: Self-checking bench for the radio configuration register bank.
// Assumes: The bench drives every input port itself; the design carries its own assertions.
// Notes: Each scenario is a task that drives the bank and judges the result.
`timescale 1ns/1ps
`include "rcb_map.svh"
module rcb_bank_test
  import rcb_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] strength = 8'h00;
  logic crc_ok = 1'b0;
  logic tune = 1'b0;
  logic [7:0] rdata, ook_cfg, tx_cfg, clk_cfg, pay_cfg, node, pkt_cfg, fifo_cfg;
  logic [2:0] chip;
  logic [1:0] band, vco, modsel, dmode, ookt, gain;
  logic div;
  logic [31:0] sync;
  int fail_count = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  rcb_bank u_rcb_bank (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .STRENGTH_I(strength), .CRC_OK_I(crc_ok), .TUNE_CYCLE_I(tune),
    .CHIP_STATE_O(chip), .BAND_SELECT_O(band), .VCO_TUNE_OFFSET_O(vco), .DIVIDER_SET_SELECT_O(div),
    .MODULATION_SELECT_O(modsel), .DATA_MODE_O(dmode), .OOK_THRESHOLD_TYPE_O(ookt),
    .INTERMEDIATE_GAIN_SELECT_O(gain), .SYNC_WORD_O(sync), .OOK_CONFIG_O(ook_cfg),
    .TRANSMIT_CONFIG_O(tx_cfg), .CLOCK_OUTPUT_O(clk_cfg), .PAYLOAD_CONFIG_O(pay_cfg),
    .NODE_ADDRESS_O(node), .PACKET_CONFIG_O(pkt_cfg), .FIFO_CRC_CONFIG_O(fifo_cfg));

  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask

  task automatic settle();
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    settle();
    chk(nm, {24'h0, e}, {24'h0, rdata});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rchk("general", `RCB_ADDR_GENERAL, `RCB_RST_GENERAL);
    rchk("datamod", `RCB_ADDR_DATAMOD, `RCB_RST_DATAMOD);
    chk("chip", RCB_STANDBY, chip);
    chk("band", 2'b01, band);
    chk("vco", 2'b00, vco);
    chk("div", 1'b0, div);
    chk("mod", RCB_MOD_FSK, modsel);
    chk("dmode", RCB_CONTINUOUS, dmode);
    chk("ookt", 2'b01, ookt);
    chk("node", 8'h00, node);
    chk("sync", 32'h0, sync);
  endtask

  task automatic t_general();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      v = {i[2:0], 2'(i % 3), 2'(i % 4), i[0]};
      bus(1'b1, 1'b0, `RCB_ADDR_GENERAL, v);
      settle();
      chk("chip", v[7:5], chip);
      chk("band", v[4:3], band);
      chk("vco", v[2:1], vco);
      chk("div", v[0], div);
      rchk("general", `RCB_ADDR_GENERAL, v);
    end
    bus(1'b1, 1'b0, `RCB_ADDR_GENERAL, 8'h4B);
    rchk("general b2b", `RCB_ADDR_GENERAL, 8'h4B);
  endtask

  task automatic t_datamod();
    logic [7:0] tbl [4] = '{8'h88, 8'h61, 8'h96, 8'h6F};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 1'b0, `RCB_ADDR_DATAMOD, tbl[i]);
      settle();
      chk("mod", tbl[i][7:6], modsel);
      chk("dmode", tbl[i][2] ? 2'b10 : {1'b0, tbl[i][5]}, dmode);
      chk("ookt", tbl[i][4:3], ookt);
      chk("gain", tbl[i][1:0], gain);
    end
  endtask

  task automatic t_tune();
    bus(1'b1, 1'b0, `RCB_ADDR_GENERAL, 8'h2A);
    settle();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      tune <= 1'b1;
      @(posedge clk);
      tune <= 1'b0;
      #1;
      chk("vco", i[0] ? 2'b01 : 2'b10, vco);
    end
    rchk("general", `RCB_ADDR_GENERAL, 8'h2A);
  endtask

  task automatic t_sync_and_others();
    bus(1'b1, 1'b0, `RCB_ADDR_SYNC1, 8'hA1);
    bus(1'b1, 1'b0, `RCB_ADDR_SYNC2, 8'hB2);
    bus(1'b1, 1'b0, `RCB_ADDR_SYNC3, 8'hC3);
    bus(1'b1, 1'b0, `RCB_ADDR_SYNC4, 8'hD4);
    bus(1'b1, 1'b0, `RCB_ADDR_OOK, 8'h15);
    bus(1'b1, 1'b0, `RCB_ADDR_TX, 8'h1A);
    bus(1'b1, 1'b0, `RCB_ADDR_CLKOUT, 8'h1B);
    bus(1'b1, 1'b0, `RCB_ADDR_PAYLOAD, 8'h1C);
    bus(1'b1, 1'b0, `RCB_ADDR_NODE, 8'h1D);
    bus(1'b1, 1'b0, `RCB_ADDR_FIFOCRC, 8'h1F);
    bus(1'b1, 1'b0, `RCB_ADDR_PACKET, 8'hFF);
    bus(1'b1, 1'b0, `RCB_ADDR_STRENGTH, 8'hEE);
    bus(1'b1, 1'b0, 8'h05, 8'hFF);
    settle();
    chk("sync", 32'hA1B2C3D4, sync);
    chk("ook", 8'h15, ook_cfg);
    chk("tx", 8'h1A, tx_cfg);
    chk("clkout", 8'h1B, clk_cfg);
    chk("payload", 8'h1C, pay_cfg);
    chk("node", 8'h1D, node);
    chk("fifo", 8'h1F, fifo_cfg);
    chk("packet", 8'hFE, pkt_cfg);
    rchk("sync1", `RCB_ADDR_SYNC1, 8'hA1);
    rchk("sync4", `RCB_ADDR_SYNC4, 8'hD4);
    rchk("unmapped", 8'h05, 8'h00);
    rchk("general", `RCB_ADDR_GENERAL, 8'h2A);
    @(posedge clk);
    strength <= 8'h3C;
    crc_ok <= 1'b1;
    rchk("strength", `RCB_ADDR_STRENGTH, 8'h3C);
    rchk("packet", `RCB_ADDR_PACKET, 8'hFF);
  endtask

  task automatic t_rereset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("node", 8'h00, node);
    chk("sync", 32'h0, sync);
    rchk("general", `RCB_ADDR_GENERAL, `RCB_RST_GENERAL);
    rchk("datamod", `RCB_ADDR_DATAMOD, `RCB_RST_DATAMOD);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_general();
    t_datamod();
    t_tune();
    t_sync_and_others();
    t_rereset();
    summarize();
  end
endmodule
